// file: ev_if.sv
// Synchronised event input levels and rising edges
`timescale 1ns/1ps
interface ev_if #(
	parameter int N = 4
);
	logic [N-1:0] level;
	logic [N-1:0] rise;

	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface

// file: event_input_setting_guard.sv
// Event input function decode, setting guards and set point limiter
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "evg_params.svh"
module event_input_setting_guard
	import evg_pkg::*;
#(
	parameter int SP_W = 16
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [`EVG_EV_NUM-1:0] event_in,
	input wire logic program_running,
	input wire logic [`EVG_ALARM_NUM-1:0] alarm_event,
	input wire logic comms_wr,
	input wire logic signed [SP_W-1:0] comms_sp,
	output logic signed [SP_W-1:0] setpoint,
	output logic [`EVG_ALARM_NUM-1:0] alarm_latch,
	output logic setting_locked,
	output logic comms_write_en,
	output logic wait_enable,
	output logic comms_refused
);
	localparam int EV_N = `EVG_EV_NUM;
	localparam int FW = `EVG_FLD_W;

	if (SP_W < 2 || SP_W > 32) $error("SP_W must lie in 2..32");

	function automatic logic signed [SP_W-1:0] clamp(
		input logic signed [SP_W-1:0] v,
		input logic signed [SP_W-1:0] lo,
		input logic signed [SP_W-1:0] hi
	);
		if (v > hi)
			return hi;
		else if (v < lo)
			return lo;
		else
			return v;
	endfunction

	ev_if #(.N(EV_N)) ev ();

	event_sync #(.N(EV_N)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.pin(event_in),
		.ev(ev)
	);

	logic wait_q;
	logic [31:0] rdata_q;
	logic [EV_N*FW-1:0] assign_q;
	logic signed [SP_W-1:0] lim_hi_q;
	logic signed [SP_W-1:0] lim_lo_q;
	logic signed [SP_W-1:0] scale_hi_q;
	logic signed [SP_W-1:0] scale_lo_q;
	logic signed [SP_W-1:0] sp_q;
	logic [15:0] cfg_q;
	logic [`EVG_ALARM_NUM-1:0] latch_q;
	logic locked_q;
	logic cwen_q;
	logic wait_en_q;
	logic refused_q;

	// Bus decode
	wire take = (avs_read | avs_write) & wait_q;
	wire commit = avs_write & ~wait_q;
	wire sel_asg = avs_address == `EVG_OFS_ASSIGN;
	wire sel_lhi = avs_address == `EVG_OFS_LIM_HI;
	wire sel_llo = avs_address == `EVG_OFS_LIM_LO;
	wire sel_sp = avs_address == `EVG_OFS_SETPOINT;
	wire sel_shi = avs_address == `EVG_OFS_SCALE_HI;
	wire sel_slo = avs_address == `EVG_OFS_SCALE_LO;
	wire sel_cfg = avs_address == `EVG_OFS_INPUT_CFG;
	wire sel_sts = avs_address == `EVG_OFS_STATUS;

	wire [31:0] sts_w = (32'(ev.level) << `EVG_STS_LEVEL_LSB)
		| (32'(locked_q) << `EVG_STS_LOCKED)
		| (32'(cwen_q) << `EVG_STS_CWEN)
		| (32'(wait_en_q) << `EVG_STS_WAIT)
		| (32'(program_running) << `EVG_STS_RUN)
		| (32'(latch_q) << `EVG_STS_LATCH_LSB);

	// Read mux, also the old word for byte-lane merging
	wire [31:0] rdata_w = sel_asg ? 32'(assign_q)
		: sel_lhi ? 32'($unsigned(lim_hi_q))
		: sel_llo ? 32'($unsigned(lim_lo_q))
		: sel_sp ? 32'($unsigned(sp_q))
		: sel_shi ? 32'($unsigned(scale_hi_q))
		: sel_slo ? 32'($unsigned(scale_lo_q))
		: sel_cfg ? 32'(cfg_q)
		: sel_sts ? sts_w
		: 32'h0000_0000;

	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] wmerge = (rdata_w & ~be_mask) | (avs_writedata & be_mask);
	wire signed [SP_W-1:0] wval = $signed(wmerge[SP_W-1:0]);
	wire [FW-1:0] f3_w = wmerge[2*FW +: FW];

	// Per-input function decode
	logic [EV_N-1:0] sg_v;
	logic [EV_N-1:0] cg_ok;
	logic [EV_N-1:0] lc_v;
	logic [EV_N-1:0] wt_v;
	logic [EV_N*FW-1:0] asg_new;

	genvar i;
	for (i = 0; i < EV_N; i++)
	begin : g_in
		fn_e fn_w;
		assign fn_w = fn_e'(assign_q[i*FW +: FW]);
		assign sg_v[i] = (i < 2) && fn_w == setting_write_guard_fn && ev.level[i];
		assign cg_ok[i] = fn_w != comms_write_guard_fn || ev.level[i];
		assign lc_v[i] = (i < 2) && fn_w == alarm_latch_clear_fn && ev.rise[i];
		assign wt_v[i] = (i < 2) && fn_w == wait_control_fn && ev.level[i];
		// Inputs 1 and 2 keep their old code when comms guard is written
		assign asg_new[i*FW +: FW] =
			((i < 2) && fn_e'(wmerge[i*FW +: FW]) == comms_write_guard_fn)
			? assign_q[i*FW +: FW] : wmerge[i*FW +: FW];
	end

	wire sg_on = |sg_v;
	wire lc_any = |lc_v;
	wire wt_on = |wt_v;
	wire cw_ok = &cg_ok;
	wire [EV_N-1:0] rise_w = ev.rise;

	// Set point and limiter next values
	wire wr_sp_bus = commit & sel_sp & ~locked_q;
	wire comms_take = comms_wr & cwen_q;
	wire scale_chg = commit & (sel_shi | sel_slo | sel_cfg);
	wire signed [SP_W-1:0] scale_hi_d = (commit & sel_shi) ? wval : scale_hi_q;
	wire signed [SP_W-1:0] scale_lo_d = (commit & sel_slo) ? wval : scale_lo_q;
	wire signed [SP_W-1:0] lim_hi_d = scale_chg ? scale_hi_d
		: (commit & sel_lhi) ? wval : lim_hi_q;
	wire signed [SP_W-1:0] lim_lo_d = scale_chg ? scale_lo_d
		: (commit & sel_llo) ? wval : lim_lo_q;
	wire signed [SP_W-1:0] sp_src = wr_sp_bus ? wval : comms_take ? comms_sp : sp_q;
	// Clamp against the new limits every cycle
	wire signed [SP_W-1:0] sp_d = clamp(sp_src, lim_lo_d, lim_hi_d);

	// Set wins over clear for each latch
	wire [`EVG_ALARM_NUM-1:0] latch_d = (latch_q & ~{`EVG_ALARM_NUM{lc_any}}) | alarm_event;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			wait_q <= ~take;
			if (take)
				rdata_q <= rdata_w;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			assign_q <= (EV_N*FW)'(`EVG_RST_ASSIGN);
			cfg_q <= `EVG_RST_CFG;
			scale_hi_q <= $signed(SP_W'(`EVG_RST_SCALE_HI));
			scale_lo_q <= $signed(SP_W'(`EVG_RST_SCALE_LO));
		end
		else
		begin
			if (commit & sel_asg)
				assign_q <= asg_new;
			if (commit & sel_cfg)
				cfg_q <= wmerge[15:0];
			scale_hi_q <= scale_hi_d;
			scale_lo_q <= scale_lo_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			lim_hi_q <= $signed(SP_W'(`EVG_RST_SCALE_HI));
			lim_lo_q <= $signed(SP_W'(`EVG_RST_SCALE_LO));
			sp_q <= $signed(SP_W'(`EVG_RST_SP));
		end
		else
		begin
			lim_hi_q <= lim_hi_d;
			lim_lo_q <= lim_lo_d;
			sp_q <= sp_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			latch_q <= '0;
			locked_q <= 1'b0;
			cwen_q <= 1'b1;
			wait_en_q <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			latch_q <= latch_d;
			locked_q <= sg_on;
			cwen_q <= cw_ok;
			wait_en_q <= wt_on & program_running;
			refused_q <= comms_wr & ~cwen_q;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign setpoint = sp_q;
	assign alarm_latch = latch_q;
	assign setting_locked = locked_q;
	assign comms_write_en = cwen_q;
	assign wait_enable = wait_en_q;
	assign comms_refused = refused_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	chk_guard_lock: assert property (##1 setting_locked == $past(sg_on))
		else $error("Setting lock does not follow guard input");

	chk_locked_write: assert property (
		(commit && sel_sp && setting_locked && !comms_wr && !scale_chg)
		|=> $stable(setpoint))
		else $error("Set point changed while settings locked");

	chk_asg_reject: assert property (
		(commit && sel_asg && fn_e'(wmerge[FW-1:0]) == comms_write_guard_fn)
		|=> fn_e'(assign_q[FW-1:0]) != comms_write_guard_fn)
		else $error("Comms guard accepted on input 1");

	chk_asg_store: assert property ((commit && sel_asg) |=> assign_q[2*FW +: FW] == $past(f3_w))
		else $error("Input 3 assignment not stored");

	chk_comms_refuse: assert property ((comms_wr && !comms_write_en) |=> comms_refused)
		else $error("Guarded comms write not refused");

	chk_latch_clear: assert property ((lc_any && alarm_event == '0) |=> alarm_latch == '0)
		else $error("Alarm latches not cleared");

	chk_latch_set: assert property (alarm_event[0] |=> alarm_latch[0])
		else $error("Alarm event lost");

	chk_wait_follow: assert property ((program_running && wt_on) |=> wait_enable)
		else $error("Wait not enabled by input");

	chk_wait_run: assert property (!program_running |=> !wait_enable)
		else $error("Wait enabled outside program operation");

	chk_sp_range: assert property ((lim_lo_q <= lim_hi_q) |-> (sp_q >= lim_lo_q && sp_q <= lim_hi_q))
		else $error("Set point outside limits");

	chk_sp_force: assert property (
		(commit && sel_llo && wval > sp_q && wval <= lim_hi_q && !comms_wr)
		|=> sp_q == lim_lo_q)
		else $error("Set point not forced to lower limit");

	chk_limit_reset: assert property (
		scale_chg |=> (lim_hi_q == scale_hi_q && lim_lo_q == scale_lo_q))
		else $error("Limits not reset to scaling");

	chk_rise_once: assert property ((rise_w != '0) |=> (rise_w & $past(rise_w)) == '0)
		else $error("Edge pulse lasted more than one cycle");

	chk_bus_wait: assert property (take |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("Bus answer not one wait state");

	cov_latch_clear: cover property (lc_any && alarm_latch != '0);
	cov_comms_refused: cover property (comms_refused);
	cov_sp_clamped: cover property (wr_sp_bus && wval > lim_hi_q);
	cov_wait_on: cover property (wait_enable);

endmodule // event_input_setting_guard

// file: event_sync.sv
// Two-stage synchroniser and rising edge detect for the event inputs
`timescale 1ns/1ps
module event_sync #(
	parameter int N = 4
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [N-1:0] pin,
	ev_if.src ev
);
	logic [N-1:0] meta_q;
	logic [N-1:0] sync_q;
	logic [N-1:0] prev_q;

	if (N < 1) $error("event_sync needs at least one input");

	genvar i;
	for (i = 0; i < N; i++)
	begin : g_bit
		always_ff @(posedge clk)
		begin
			if (!rstn)
			begin
				meta_q[i] <= 1'b0;
				sync_q[i] <= 1'b0;
				prev_q[i] <= 1'b0;
			end
			else
			begin
				meta_q[i] <= pin[i];
				sync_q[i] <= meta_q[i];
				prev_q[i] <= sync_q[i];
			end
		end
		assign ev.level[i] = sync_q[i];
		// One pulse per OFF-to-ON change
		assign ev.rise[i] = sync_q[i] & ~prev_q[i];
	end

endmodule // event_sync

// file: evg_contacts.sv
// Switch contact model driving the event inputs
`timescale 1ns/1ps
module evg_contacts
(
	input wire logic clk,
	input wire logic [3:0] want,
	output logic [3:0] event_in
);
	initial event_in = 4'h0;
	// Contacts change just after a clock edge
	always @(posedge clk)
	begin
		event_in <= want;
	end
endmodule // evg_contacts

// file: evg_params.svh
// Offsets, field positions, reset values and counts for the event input guard
`ifndef EVG_PARAMS_SVH
`define EVG_PARAMS_SVH

`define EVG_EV_NUM 4
`define EVG_ALARM_NUM 6
`define EVG_FLD_W 4
`define EVG_WAIT_IN_NUM 2

`define EVG_OFS_ASSIGN 6'h00
`define EVG_OFS_LIM_HI 6'h04
`define EVG_OFS_LIM_LO 6'h08
`define EVG_OFS_SETPOINT 6'h0c
`define EVG_OFS_SCALE_HI 6'h10
`define EVG_OFS_SCALE_LO 6'h14
`define EVG_OFS_INPUT_CFG 6'h18
`define EVG_OFS_STATUS 6'h1c

`define EVG_STS_LEVEL_LSB 0
`define EVG_STS_LOCKED 4
`define EVG_STS_CWEN 5
`define EVG_STS_WAIT 6
`define EVG_STS_RUN 7
`define EVG_STS_LATCH_LSB 8

`define EVG_RST_ASSIGN 16'h0000
`define EVG_RST_SCALE_HI 16'h0064
`define EVG_RST_SCALE_LO 16'h0000
`define EVG_RST_SP 16'h0000
`define EVG_RST_CFG 16'h0000

`endif

// file: evg_pkg.sv
// Types shared by the event input guard modules
package evg_pkg;

	typedef enum logic [3:0] {
		fn_none = 4'h0,
		setting_write_guard_fn = 4'h1,
		comms_write_guard_fn = 4'h2,
		alarm_latch_clear_fn = 4'h3,
		wait_control_fn = 4'h4
	} fn_e;

endpackage

// file: testbench.sv
// Self-checking bench for the event input guard
`timescale 1ns/1ps
`include "evg_params.svh"
module testbench;
	import evg_pkg::*;
	logic clk = 0, rstn = 0, avs_read = 0, avs_write = 0, program_running = 0, comms_wr = 0;
	logic [5:0] avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic avs_waitrequest, setting_locked, comms_write_en, wait_enable, comms_refused;
	logic [3:0] want = 4'h0, event_in;
	logic [5:0] alarm_event = 6'h00, alarm_latch;
	logic signed [15:0] comms_sp = 16'sh0, setpoint;
	int fails = 0, samples_checked = 0, cyc = 0, seed = 89, hi = 100, lo = 0, sp = 0, v;
	int sp_log[$];
	always #5 clk = ~clk;
	evg_contacts u_contacts (.clk(clk), .want(want), .event_in(event_in));
	event_input_setting_guard u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.event_in(event_in), .program_running(program_running), .alarm_event(alarm_event),
		.comms_wr(comms_wr), .comms_sp(comms_sp), .setpoint(setpoint),
		.alarm_latch(alarm_latch), .setting_locked(setting_locked),
		.comms_write_en(comms_write_en), .wait_enable(wait_enable),
		.comms_refused(comms_refused));
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fails = fails + 1;
			final_report;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task cw(input int val);
		@(posedge clk);
		comms_sp <= val[15:0];
		comms_wr <= 1'b1;
		@(posedge clk);
		comms_wr <= 1'b0;
		@(negedge clk);
	endtask
	task alarms;
		@(posedge clk);
		alarm_event <= 6'h3f;
		@(posedge clk);
		alarm_event <= 6'h00;
		wt(2);
	endtask
	function int clp(input int x);
		return x > hi ? hi : (x < lo ? lo : x);
	endfunction
	task sp_chk;
		sp_log.push_back(sp);
		bus(0, `EVG_OFS_SETPOINT, 0);
		chk(q[15:0], sp_log[0]);
		chk(setpoint[15:0], sp_log.pop_front());
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		bus(0, `EVG_OFS_LIM_HI, 0);
		chk(q, 32'h64);
		bus(0, 6'h20, 0);
		chk(q, 32'h0);
		$display("reset test done");
		repeat (5)
		begin
			v = $random(seed) % 300;
			bus(1, `EVG_OFS_SETPOINT, v);
			sp = clp(v);
			sp_chk;
		end
		bus(1, `EVG_OFS_LIM_HI, 32'h14);
		hi = 20;
		sp = clp(sp);
		sp_chk;
		bus(1, `EVG_OFS_SETPOINT, 32'h0a);
		sp = 10;
		sp_chk;
		bus(1, `EVG_OFS_LIM_LO, 32'h0f);
		lo = 15;
		sp = clp(sp);
		sp_chk;
		bus(1, `EVG_OFS_SCALE_HI, 32'h50);
		hi = 80;
		lo = 0;
		bus(0, `EVG_OFS_LIM_HI, 0);
		chk(q, 32'h50);
		bus(0, `EVG_OFS_LIM_LO, 0);
		chk(q, 32'h0);
		bus(1, `EVG_OFS_SCALE_LO, 32'h05);
		bus(1, `EVG_OFS_LIM_HI, 32'h3c);
		bus(1, `EVG_OFS_INPUT_CFG, 32'h1);
		lo = 5;
		bus(0, `EVG_OFS_LIM_HI, 0);
		chk(q, 32'h50);
		bus(0, `EVG_OFS_LIM_LO, 0);
		chk(q, 32'h5);
		sp = clp(sp);
		sp_chk;
		$display("limit test done");
		bus(1, `EVG_OFS_ASSIGN, 32'h0001);
		want <= 4'h1;
		wt(4);
		chk(setting_locked, 1'b1);
		bus(1, `EVG_OFS_SETPOINT, 32'h32);
		sp_chk;
		want <= 4'h0;
		wt(4);
		chk(setting_locked, 1'b0);
		bus(1, `EVG_OFS_SETPOINT, 32'h32);
		sp = 50;
		sp_chk;
		$display("setting guard test done");
		bus(1, `EVG_OFS_ASSIGN, 32'h0202);
		bus(0, `EVG_OFS_ASSIGN, 0);
		chk(q[15:0], 16'h0201);
		wt(4);
		chk(comms_write_en, 1'b0);
		cw(30);
		chk(comms_refused, 1'b1);
		want <= 4'h4;
		wt(4);
		chk(comms_write_en, 1'b1);
		cw(30);
		chk(comms_refused, 1'b0);
		sp = 30;
		wt(2);
		sp_chk;
		$display("comms guard test done");
		want <= 4'h0;
		bus(1, `EVG_OFS_ASSIGN, 32'h0030);
		alarms;
		chk(alarm_latch, 6'h3f);
		want <= 4'h2;
		wt(4);
		chk(alarm_latch, 6'h00);
		alarms;
		chk(alarm_latch, 6'h3f);
		want <= 4'h0;
		$display("latch clear test done");
		bus(1, `EVG_OFS_ASSIGN, 32'h0004);
		want <= 4'h1;
		wt(4);
		chk(wait_enable, 1'b0);
		@(posedge clk);
		program_running <= 1'b1;
		wt(3);
		chk(wait_enable, 1'b1);
		want <= 4'h0;
		wt(4);
		chk(wait_enable, 1'b0);
		$display("wait test done");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk(setpoint, 32'h0);
		chk(alarm_latch, 6'h00);
		chk(setting_locked, 1'b0);
		chk(comms_write_en, 1'b1);
		chk(wait_enable, 1'b0);
		chk(avs_waitrequest, 1'b1);
		bus(0, `EVG_OFS_ASSIGN, 0);
		chk(q, 32'h0);
		bus(0, `EVG_OFS_LIM_LO, 0);
		chk(q, 32'h0);
		bus(0, `EVG_OFS_LIM_HI, 0);
		chk(q, 32'h64);
		bus(0, `EVG_OFS_STATUS, 0);
		chk(q, 32'ha0);
		$display("second reset test done");
		final_report;
	end
endmodule // testbench
